// ---- dv/dss_disk_model.sv ----
// behavioural drive: seek motion and one rotating track per head
// assumes the sequencer samples disk lines only on their pulses
`timescale 1ns/1ps

module dss_disk_model (
	input wire logic clock,
	input wire logic resetn,
	input wire logic [7:0] delay,
	input wire logic seekHomeCmd,
	input wire logic seekMoveCmd,
	input wire logic [3:0] diskHead,
	output logic seekHomeDone,
	output logic seekOnCylinder,
	output logic diskIndex,
	output logic diskAddrValid,
	output logic [16:0] diskAddr,
	output logic diskReadOnly,
	output logic diskCharStrobe,
	output logic [5:0] diskCharIn
);
	logic [8:0] seekCnt_q;
	logic moving_q;
	logic [1:0] tick_q;
	logic [6:0] slot_q;
	logic [4:0] sect_q;
	logic [3:0] dig;
	logic addrSlot, charSlot;
	assign dig = 4'((int'(sect_q) + int'(slot_q) - 2) % 10);
	assign addrSlot = tick_q == 2'h0 && slot_q == 7'h01;
	assign charSlot = tick_q == 2'h0 && slot_q >= 7'h02;

	// ==========================================================
	// access motion, delay chosen by the bench
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			seekCnt_q <= '0;
			moving_q <= 1'b0;
			seekHomeDone <= 1'b0;
			seekOnCylinder <= 1'b0;
		end else begin
			seekHomeDone <= 1'b0;
			if (seekHomeCmd || seekMoveCmd) begin
				seekCnt_q <= {1'b0, delay} + 9'h001;
				moving_q <= seekMoveCmd;
				seekOnCylinder <= 1'b0;
			end else if (seekCnt_q != 9'h000) begin
				seekCnt_q <= seekCnt_q - 9'h001;
				seekHomeDone <= seekCnt_q == 9'h001 && !moving_q;
				seekOnCylinder <= seekCnt_q == 9'h001 && moving_q;
			end
		end
	end

	// ==========================================================
	// rotation: index, address, 100 characters per sector, one slot every three clocks
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			tick_q <= '0;
			slot_q <= '0;
			sect_q <= '0;
			diskIndex <= 1'b0;
			diskAddrValid <= 1'b0;
			diskCharStrobe <= 1'b0;
			diskAddr <= '0;
			diskReadOnly <= 1'b0;
			diskCharIn <= '0;
		end else begin
			tick_q <= tick_q == 2'h2 ? 2'h0 : tick_q + 2'h1;
			diskIndex <= tick_q == 2'h0 && slot_q == 7'h00 && sect_q == 5'h00;
			diskAddrValid <= addrSlot;
			diskCharStrobe <= charSlot;
			// released lines flip every clock so a stale value never holds; a flipped character keeps odd parity
			diskAddr <= addrSlot ? 17'h00190 + 17'(diskHead) * 17'h00014 + 17'(sect_q) : ~diskAddr;
			diskReadOnly <= addrSlot ? 1'b0 : ~diskReadOnly;
			diskCharIn <= charSlot ? {~^dig, 1'b0, dig} : ~diskCharIn;
			if (tick_q == 2'h2) begin
				slot_q <= slot_q == 7'h65 ? 7'h00 : slot_q + 7'h01;
				if (slot_q == 7'h65) begin
					sect_q <= sect_q == 5'h13 ? 5'h00 : sect_q + 5'h01;
				end
			end
		end
	end
endmodule

// ---- dv/dss_sequencer_sva.sv ----
// port-level assertions for the disk sector sequencer
// assumes clockEnable stays high while the checker is bound
`timescale 1ns/1ps

module dss_sequencer_sva
	import dss_pkg::*;
#(
	parameter int CHAR_W = 6
) (
	input wire logic clock,
	input wire logic resetn,
	input wire logic [4:0] avsAddress,
	input wire logic avsRead,
	input wire logic avsWrite,
	input wire logic [31:0] avsWritedata,
	input wire logic avsWaitrequest,
	input wire logic seekHomeCmd,
	input wire logic seekMoveCmd,
	input wire logic seekHomeDone,
	input wire logic seekOnCylinder,
	input wire logic diskCharStrobe,
	input wire logic [CHAR_W-1:0] diskCharIn,
	input wire logic diskWriteGate,
	input wire logic coreWrEn,
	input wire logic [CHAR_W-1:0] coreWrData,
	input wire logic seekCompleteIrq
);
	// ==========================================================
	// cycles a pending request has waited so far
	int waitCnt_q;
	logic isSeek;
	assign isSeek = avsAddress == REG_CTRL && avsWritedata[7:0] == OP_SEEK && avsWritedata[11:8] == MOD_SEEK;
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			waitCnt_q <= 0;
		end else begin
			waitCnt_q <= ((avsRead || avsWrite) && avsWaitrequest) ? waitCnt_q + 1 : 0;
		end
	end

	// ==========================================================
	// assertions
	default clocking @(posedge clock); endclocking
	default disable iff (!resetn);
	sequence sSeekAck;
		avsWrite && !avsWaitrequest && isSeek;
	endsequence
	sequence sOtherAck;
		(avsRead || (avsWrite && !isSeek)) && !avsWaitrequest;
	endsequence
	a_seek_hold: assert property (sSeekAck |-> waitCnt_q == SEEK_HOLD_CYC)
		else $error("seek write not held for the interlock time");
	a_plain_ack: assert property (sOtherAck |-> waitCnt_q == 1)
		else $error("plain access not answered after one cycle");
	a_ack_once: assert property (!avsWaitrequest |=> avsWaitrequest)
		else $error("waitrequest low for more than one cycle");
	a_home_pulse: assert property (seekHomeCmd |=> !seekHomeCmd && !seekMoveCmd)
		else $error("home command not a lone pulse");
	a_home_first: assert property (seekMoveCmd |-> $past(seekHomeDone))
		else $error("move issued before home reached");
	a_done_irq: assert property ($rose(seekOnCylinder) |-> ##[2:4] seekCompleteIrq)
		else $error("seek complete not signalled");
	a_core_data: assert property (coreWrEn |-> $past(diskCharStrobe) && coreWrData == $past(diskCharIn))
		else $error("core write not the strobed disk character");
	a_core_pulse: assert property (coreWrEn |=> !coreWrEn)
		else $error("core write longer than one cycle");
	a_gate_read: assert property (diskWriteGate |-> !coreWrEn)
		else $error("core written while writing to disk");
endmodule

// ---- dv/test_disk_sector_sequencer.sv ----
// self-checking bench: seek, sector read with core wrap, missing sector, compare, switch refusal
// assumes a 64-position core modelled here and the drive model beside it
`timescale 1ns/1ps

module test_disk_sector_sequencer;
	import dss_pkg::*;
	logic clock, resetn, avsRead, avsWrite, avsWaitrequest, writeAddrSwitch, seekHomeCmd, seekMoveCmd;
	logic seekHomeDone, seekOnCylinder, diskIndex, diskAddrValid, diskReadOnly, diskCharStrobe;
	logic diskWriteGate, coreWrEn, seekCompleteIrq;
	logic [4:0] avsAddress;
	logic [31:0] avsWritedata, avsReaddata, rnd, q;
	logic [8:0] seekCylinder;
	logic [3:0] diskHead;
	logic [16:0] diskAddr, coreAddr;
	logic [5:0] diskCharIn, diskCharOut, coreWrData, coreRdData;
	logic [7:0] delay;
	logic [5:0] core [0:63];
	logic [22:0] expQ [$];
	int errTotal, compares, start;

	dss_sequencer #(.CORE_TOP(17'h0003F)) dss_sequencer_i (.clock, .resetn, .clockEnable(1'b1), .avsAddress,
		.avsRead, .avsWrite, .avsWritedata, .avsByteenable(4'hF), .avsReaddata, .avsWaitrequest,
		.writeAddrSwitch, .seekHomeCmd, .seekMoveCmd, .seekCylinder, .seekHomeDone, .seekOnCylinder,
		.diskHead, .diskIndex, .diskAddrValid, .diskAddr, .diskReadOnly, .diskCharStrobe, .diskCharIn,
		.diskWriteGate, .diskCharOut, .coreAddr, .coreWrEn, .coreWrData, .coreRdData, .seekCompleteIrq);
	dss_disk_model dss_disk_model_i (.clock, .resetn, .delay, .seekHomeCmd, .seekMoveCmd, .diskHead,
		.seekHomeDone, .seekOnCylinder, .diskIndex, .diskAddrValid, .diskAddr, .diskReadOnly,
		.diskCharStrobe, .diskCharIn);
	assign coreRdData = core[coreAddr[5:0]];

	// ==========================================================
	// helpers
	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		s = s ^ (s << 5);
		return s;
	endfunction
	function automatic logic [5:0] chr(input logic [3:0] d);
		return {~^d, 1'b0, d};
	endfunction
	task automatic results();
		if (errTotal == 0 && compares > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	task automatic fail(input string m);
		errTotal++;
		$display("Error at %0t: %s", $time, m);
	endtask
	task automatic chkReg(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) fail($sformatf("got %h expected %h", got, exp));
	endtask
	// one access, held until waitrequest is low
	task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
		@(posedge clock);
		avsRead <= !w;
		avsWrite <= w;
		avsAddress <= a;
		avsWritedata <= d;
		do @(posedge clock);
		while (avsWaitrequest !== 1'b0);
		q = avsReaddata;
		avsRead <= 1'b0;
		avsWrite <= 1'b0;
	endtask
	task automatic rd(input logic [4:0] a, input logic [31:0] exp);
		bus(1'b0, a, '0);
		chkReg(q, exp);
	endtask
	task automatic waitStat(input int b, input logic v);
		do bus(1'b0, REG_STATUS, '0);
		while (q[b] !== v);
	endtask

	// ==========================================================
	// core model and write checker
	always @(posedge clock) begin
		if (resetn && coreWrEn === 1'b1) begin
			core[coreAddr[5:0]] <= coreWrData;
			compares++;
			if (expQ.size() == 0) fail("unexpected core write");
			else if ({coreAddr, coreWrData} !== expQ.pop_front()) fail("core write mismatch");
		end
	end

	initial begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end
	initial begin
		repeat (60000) @(posedge clock);
		fail("watchdog");
		results();
	end

	// ==========================================================
	// scenarios
	initial begin
		resetn = 1'b0;
		avsRead = 1'b0;
		avsWrite = 1'b0;
		avsAddress = '0;
		avsWritedata = '0;
		writeAddrSwitch = 1'b0;
		errTotal = 0;
		compares = 0;
		rnd = xs(32'h58B71797);
		delay = rnd[7:0];
		repeat (20) @(posedge clock);
		resetn <= 1'b1;
		rd(REG_STATUS, '0);
		rnd = xs(rnd);
		bus(1'b1, 5'h14, rnd);
		rd(5'h14, '0);
		// sector 425: cylinder 2, head 1
		bus(1'b1, REG_SECT, 32'h000001A9);
		bus(1'b1, REG_CTRL, 32'h00000134);
		waitStat(IND_SEEK_DONE, 1'b1);
		chkReg({23'h0, seekCylinder}, 32'h00000002);
		chkReg({31'h0, seekCompleteIrq}, 32'h00000001);
		rd(REG_STATUS, 32'h00000080);
		bus(1'b1, REG_STATUS, 32'h000001FF);
		rd(REG_STATUS, '0);
		// one checked sector that wraps core and overwrites the group mark planted in its path
		rnd = xs(rnd);
		start = int'(rnd[5:0]);
		for (int i = 0; i < 64; i++) core[i] = 6'h01;
		core[(start + 100) % 64] = 6'h2F;
		for (int j = 0; j < 100; j++) expQ.push_back({17'((start + j) % 64), chr(4'((5 + j) % 10))});
		bus(1'b1, REG_COUNT, 32'h00000001);
		bus(1'b1, REG_CORE, 32'(start));
		bus(1'b1, REG_CTRL, 32'h00000036);
		waitStat(STAT_BUSY_BIT, 1'b0);
		rd(REG_STATUS, '0);
		rd(REG_SECT, 32'h000001AA);
		rd(REG_COUNT, '0);
		chkReg(32'(expQ.size()), '0);
		chkReg({28'h0, diskHead}, 32'h00000001);
		// sector 399 sits on cylinder 1, head 9; the cylinder 2 track never presents it
		bus(1'b1, REG_SECT, 32'h0000018F);
		bus(1'b1, REG_COUNT, 32'h00000001);
		bus(1'b1, REG_CTRL, 32'h00000236);
		waitStat(STAT_BUSY_BIT, 1'b0);
		rd(REG_STATUS, 32'h00000010);
		bus(1'b1, REG_STATUS, 32'h000001FF);
		bus(1'b1, REG_SECT, 32'h000001A9);
		bus(1'b1, REG_CORE, 32'(start));
		bus(1'b1, REG_CTRL, 32'h00000336);
		waitStat(STAT_BUSY_BIT, 1'b0);
		rd(REG_STATUS, 32'h00000020);
		bus(1'b1, REG_STATUS, 32'h000001FF);
		// a sector write with the write-address switch on is refused
		writeAddrSwitch <= 1'b1;
		bus(1'b1, REG_CTRL, 32'h00000238);
		rd(REG_STATUS, 32'h00000100);
		results();
	end
endmodule

bind dss_sequencer dss_sequencer_sva #(.CHAR_W(CHAR_W)) dss_sequencer_sva_i (.clock, .resetn, .avsAddress, .avsRead,
	.avsWrite, .avsWritedata, .avsWaitrequest, .seekHomeCmd, .seekMoveCmd, .seekHomeDone, .seekOnCylinder,
	.diskCharStrobe, .diskCharIn, .diskWriteGate, .coreWrEn, .coreWrData, .seekCompleteIrq);

// ---- hdl/dss_pkg.sv ----
// constants and types shared by the disk sector sequencer
// assumes a 10 MHz clock and a 32-bit Avalon-MM register bus
package dss_pkg;

	// ==========================================================
	// register map (byte addresses)
	localparam logic [4:0] REG_CTRL = 5'h00;
	localparam logic [4:0] REG_SECT = 5'h04;
	localparam logic [4:0] REG_COUNT = 5'h08;
	localparam logic [4:0] REG_CORE = 5'h0C;
	localparam logic [4:0] REG_STATUS = 5'h10;

	localparam int CTRL_OP_LSB = 0;
	localparam int CTRL_MOD_LSB = 8;
	localparam int STAT_BUSY_BIT = 16;
	localparam int STAT_SEEKING_BIT = 17;

	// indicator bit positions in the status register
	localparam int IND_W = 9;
	localparam int IND_READ = 0;
	localparam int IND_WRITE = 1;
	localparam int IND_MBR_EVEN = 2;
	localparam int IND_MBR_ODD = 3;
	localparam int IND_ADDR = 4;
	localparam int IND_WRONG_LEN = 5;
	localparam int IND_OVERFLOW = 6;
	localparam int IND_SEEK_DONE = 7;
	localparam int IND_SWITCH = 8;

	// ==========================================================
	// instruction codes (two decimal digits) and modifier digits
	localparam logic [7:0] OP_SEEK = 8'h34;
	localparam logic [7:0] OP_READ = 8'h36;
	localparam logic [7:0] OP_WRITE = 8'h38;
	localparam logic [3:0] MOD_SEEK = 4'h1;
	localparam logic [3:0] MOD_SECT_LEN = 4'h0;
	localparam logic [3:0] MOD_SECT = 4'h2;
	localparam logic [3:0] MOD_SECT_CMP = 4'h3;
	localparam logic [3:0] MOD_TRK_LEN = 4'h4;
	localparam logic [3:0] MOD_TRK_LEN_CMP = 4'h5;
	localparam logic [3:0] MOD_TRK = 4'h6;
	localparam logic [3:0] MOD_TRK_CMP = 4'h7;

	// ==========================================================
	// disk geometry and character format
	localparam int SECTORS_PER_TRACK = 20;
	localparam int SURFACES = 10;
	localparam int SECTORS_PER_CYL = 200;
	localparam int SECTOR_CHARS = 100;
	localparam int TRACK_SECTOR_CHARS = 105;
	localparam logic [3:0] GROUP_MARK_DIGIT = 4'hF;

	// ==========================================================
	// timing
	localparam int CLK_PERIOD_NS = 100;
	localparam int SEEK_HOLD_US = 160;
	localparam int SEEK_HOLD_CYC = (SEEK_HOLD_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int AVG_ACCESS_MS = 22;
	localparam int PER_SECTOR_MS = 2;

	typedef enum logic [2:0] {
		DSS_OP_NONE = 3'b000,
		DSS_OP_SEEK = 3'b001,
		DSS_OP_READ = 3'b010,
		DSS_OP_WRITE = 3'b011,
		DSS_OP_CMP = 3'b100
	} dss_op_t;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_SEARCH = 3'b001,
		ST_WAIT_INDEX = 3'b010,
		ST_XFER = 3'b011,
		ST_NEXT_ADDR = 3'b100
	} dss_state_t;

	typedef enum logic [1:0] {
		SK_IDLE = 2'b00,
		SK_HOME = 2'b01,
		SK_MOVE = 2'b10
	} dss_seek_t;

endpackage

// ---- hdl/dss_sequencer.sv ----
// disk sector sequencer: decodes disk instructions and runs seek,
// read, write and compare transfers between core storage and a drive
// assumes core storage reads combinationally at coreAddr, and that the
// drive spaces character strobes at least two clocks apart
//
// Summary of operation
// - op 34 modifier 1 is a seek
// - seek retracts home, then moves to cylinder
// - bus held 160 us on seek only
// - seek completion sets indicator 42, optional interrupt
// - modifier 0 reads (36) or writes (38), length-checked
// - modifier 2 read/write, 3 compare, unchecked
// - modifiers 4-7 are whole-track 20-sector operations
// - match sector address, transfer ascending, core wraps
// - no match within two index pulses: address check
// - next recorded address must equal incremented operand
// - head advances; cylinder end with count left overflows
// - read parity errors set 06 and 16/17, stop
// - group mark after earlier sector: wrong length
// - other core group marks are simply overwritten
// - read-only flag on sector write: address check
// - write checks each successive recorded address
// - write parity errors set 16/17 or 07, stop
// - write group mark ends transfer if length-checked; disk marks ignored
// - timing is paced by drive sector rate
// - compare mismatch stops at sector end, indicator 37
`timescale 1ns/1ps

module dss_sequencer
	import dss_pkg::*;
#(
	parameter int SA_W = 17,
	parameter int CNT_W = 10,
	parameter int CORE_W = 17,
	parameter logic [16:0] CORE_TOP = 17'h04E1F,
	parameter int CHAR_W = 6,
	parameter bit SEEK_IRQ_FITTED = 1'b1
) (
	input wire logic clock,
	input wire logic resetn,
	input wire logic clockEnable,
	input wire logic [4:0] avsAddress,
	input wire logic avsRead,
	input wire logic avsWrite,
	input wire logic [31:0] avsWritedata,
	input wire logic [3:0] avsByteenable,
	output logic [31:0] avsReaddata,
	output logic avsWaitrequest,
	input wire logic writeAddrSwitch,
	output logic seekHomeCmd,
	output logic seekMoveCmd,
	output logic [8:0] seekCylinder,
	input wire logic seekHomeDone,
	input wire logic seekOnCylinder,
	output logic [3:0] diskHead,
	input wire logic diskIndex,
	input wire logic diskAddrValid,
	input wire logic [SA_W-1:0] diskAddr,
	input wire logic diskReadOnly,
	input wire logic diskCharStrobe,
	input wire logic [CHAR_W-1:0] diskCharIn,
	output logic diskWriteGate,
	output logic [CHAR_W-1:0] diskCharOut,
	output logic [CORE_W-1:0] coreAddr,
	output logic coreWrEn,
	output logic [CHAR_W-1:0] coreWrData,
	input wire logic [CHAR_W-1:0] coreRdData,
	output logic seekCompleteIrq
);
	import dss_pkg::*;

	localparam int HOLD_W = $clog2(SEEK_HOLD_CYC + 1);

	// ==========================================================
	// helpers
	// odd parity over check, flag and numeric bits
	function automatic logic parityOk(input logic [CHAR_W-1:0] c);
		return ^c;
	endfunction

	function automatic logic isGroupMark(input logic [CHAR_W-1:0] c);
		return c[3:0] == GROUP_MARK_DIGIT;
	endfunction

	function automatic logic [31:0] mergeBytes(input logic [31:0] old, input logic [31:0] nw,
			input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// ==========================================================
	// state
	dss_state_t state_q;
	dss_seek_t seek_q;
	dss_op_t kind_q;
	logic lenChk_q, track_q;
	logic [SA_W-1:0] sectAddr_q;
	logic [CNT_W-1:0] remaining_sector_count_q;
	logic [CORE_W-1:0] coreAddr_q;
	logic [3:0] head_q;
	logic [4:0] secInTrack_q;
	logic [6:0] charCnt_q;
	logic [1:0] indexSeen_q;
	logic cmpFail_q, gmPend_q, advance_q, wrCheck_q;
	logic coreWrEn_q, diskWriteGate_q;
	logic [CHAR_W-1:0] coreWrData_q, diskCharOut_q;
	logic [IND_W-1:0] indSet_q, ind_q;
	logic seekHomeCmd_q, seekMoveCmd_q, seekIrq_q;
	logic [8:0] seekCyl_q;
	logic avsWaitrequest_q;
	logic [31:0] avsReaddata_q;
	logic [HOLD_W-1:0] holdCnt_q;

	// ==========================================================
	// instruction decode
	logic [7:0] wrOp;
	logic [3:0] modifier_digit;
	dss_op_t wrKind;
	logic wrLen, wrTrack, isSeekWr, wrAcc, busy, seeking, startOp;

	assign wrOp = avsWritedata[CTRL_OP_LSB +: 8];
	assign modifier_digit = avsWritedata[CTRL_MOD_LSB +: 4];
	assign busy = state_q != ST_IDLE;
	assign seeking = seek_q != SK_IDLE;

	always_comb begin
		wrKind = DSS_OP_NONE;
		wrLen = 1'b0;
		wrTrack = modifier_digit[2];
		if (wrOp == OP_SEEK && modifier_digit == MOD_SEEK) begin
			wrKind = DSS_OP_SEEK;
		end else if (wrOp == OP_READ || wrOp == OP_WRITE) begin
			unique case (modifier_digit)
				MOD_SECT_LEN, MOD_SECT, MOD_TRK_LEN, MOD_TRK: begin
					wrKind = (wrOp == OP_READ) ? DSS_OP_READ : DSS_OP_WRITE;
				end
				MOD_SECT_CMP, MOD_TRK_LEN_CMP, MOD_TRK_CMP: begin
					wrKind = (wrOp == OP_READ) ? DSS_OP_CMP : DSS_OP_NONE;
				end
				default: wrKind = DSS_OP_NONE;
			endcase
			wrLen = modifier_digit == MOD_SECT_LEN || modifier_digit == MOD_TRK_LEN
				|| modifier_digit == MOD_TRK_LEN_CMP;
		end
	end

	assign isSeekWr = avsWrite && avsAddress == REG_CTRL && wrKind == DSS_OP_SEEK && !busy && !seeking;
	assign wrAcc = avsWrite && !avsWaitrequest_q;
	assign startOp = wrAcc && avsAddress == REG_CTRL && !busy && !seeking;

	// ==========================================================
	// avalon slave: every access answers one clock after it appears,
	// except a seek, which holds the processor for the hand-off time
	logic [31:0] readMux;
	always_comb begin
		unique case (avsAddress)
			REG_SECT: readMux = 32'(sectAddr_q);
			REG_COUNT: readMux = 32'(remaining_sector_count_q);
			REG_CORE: readMux = 32'(coreAddr_q);
			REG_STATUS: begin
				readMux = 32'(ind_q);
				readMux[STAT_BUSY_BIT] = busy;
				readMux[STAT_SEEKING_BIT] = seeking;
			end
			default: readMux = 32'h00000000;
		endcase
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			avsWaitrequest_q <= 1'b1;
			avsReaddata_q <= 32'h00000000;
			holdCnt_q <= '0;
		end else if (clockEnable) begin
			if (!avsWaitrequest_q) begin
				avsWaitrequest_q <= 1'b1;
				holdCnt_q <= '0;
			end else if (avsRead) begin
				avsWaitrequest_q <= 1'b0;
				avsReaddata_q <= readMux;
			end else if (avsWrite) begin
				if (!isSeekWr || holdCnt_q == HOLD_W'(SEEK_HOLD_CYC - 1)) begin
					avsWaitrequest_q <= 1'b0;
				end else begin
					holdCnt_q <= holdCnt_q + 1'b1;
				end
			end
		end
	end

	// ==========================================================
	// seek: retract home, then move in, then report completion
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			seek_q <= SK_IDLE;
			seekHomeCmd_q <= 1'b0;
			seekMoveCmd_q <= 1'b0;
			seekCyl_q <= 9'h000;
		end else if (clockEnable) begin
			seekHomeCmd_q <= 1'b0;
			seekMoveCmd_q <= 1'b0;
			unique case (seek_q)
				SK_IDLE: if (startOp && wrKind == DSS_OP_SEEK) begin
					seekCyl_q <= 9'(sectAddr_q / SECTORS_PER_CYL);
					seekHomeCmd_q <= 1'b1;
					seek_q <= SK_HOME;
				end
				SK_HOME: if (seekHomeDone) begin
					seekMoveCmd_q <= 1'b1;
					seek_q <= SK_MOVE;
				end
				SK_MOVE: if (seekOnCylinder) begin
					seek_q <= SK_IDLE;
				end
				default: seek_q <= SK_IDLE;
			endcase
		end
	end

	// ==========================================================
	// transfer sequencer
	logic [CORE_W-1:0] nextCore;
	logic [6:0] lastChar;
	logic [IND_W-1:0] mbrBit;
	assign nextCore = (coreAddr_q == CORE_W'(CORE_TOP)) ? '0 : coreAddr_q + 1'b1;
	assign lastChar = track_q ? 7'(TRACK_SECTOR_CHARS - 1) : 7'(SECTOR_CHARS - 1);
	assign mbrBit = coreAddr_q[0] ? IND_W'(1 << IND_MBR_ODD) : IND_W'(1 << IND_MBR_EVEN);

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			state_q <= ST_IDLE;
			kind_q <= DSS_OP_NONE;
			lenChk_q <= 1'b0;
			track_q <= 1'b0;
			sectAddr_q <= '0;
			remaining_sector_count_q <= '0;
			coreAddr_q <= '0;
			head_q <= 4'h0;
			secInTrack_q <= 5'h00;
			charCnt_q <= 7'h00;
			indexSeen_q <= 2'h0;
			cmpFail_q <= 1'b0;
			gmPend_q <= 1'b0;
			advance_q <= 1'b0;
			wrCheck_q <= 1'b0;
			coreWrEn_q <= 1'b0;
			coreWrData_q <= '0;
			diskWriteGate_q <= 1'b0;
			diskCharOut_q <= '0;
			indSet_q <= '0;
		end else if (clockEnable) begin
			indSet_q <= '0;
			coreWrEn_q <= 1'b0;
			advance_q <= 1'b0;
			wrCheck_q <= 1'b0;
			// the core address steps the clock after each character so the
			// write strobe rises on a steady address and drops on the clock the address steps
			if (advance_q) begin
				coreAddr_q <= nextCore;
			end
			if (!busy && wrAcc && avsAddress == REG_SECT) begin
				sectAddr_q <= SA_W'(mergeBytes(32'(sectAddr_q), avsWritedata, avsByteenable));
			end
			if (!busy && wrAcc && avsAddress == REG_COUNT) begin
				remaining_sector_count_q <= CNT_W'(mergeBytes(32'(remaining_sector_count_q), avsWritedata,
					avsByteenable));
			end
			if (!busy && wrAcc && avsAddress == REG_CORE) begin
				coreAddr_q <= CORE_W'(mergeBytes(32'(coreAddr_q), avsWritedata, avsByteenable));
			end
			if (seek_q == SK_MOVE && seekOnCylinder) begin
				indSet_q[IND_SEEK_DONE] <= 1'b1;
			end
			unique case (state_q)
				ST_IDLE: if (startOp && wrKind != DSS_OP_NONE && wrKind != DSS_OP_SEEK) begin
					if (wrKind == DSS_OP_WRITE && writeAddrSwitch != wrTrack) begin
						indSet_q[IND_SWITCH] <= 1'b1;
					end else begin
						kind_q <= wrKind;
						lenChk_q <= wrLen;
						track_q <= wrTrack;
						head_q <= 4'((sectAddr_q / SECTORS_PER_TRACK) % SURFACES);
						secInTrack_q <= 5'(sectAddr_q % SECTORS_PER_TRACK);
						indexSeen_q <= 2'h0;
						cmpFail_q <= 1'b0;
						gmPend_q <= 1'b0;
						charCnt_q <= 7'h00;
						state_q <= wrTrack ? ST_WAIT_INDEX : ST_SEARCH;
					end
				end
				ST_SEARCH: begin
					if (diskIndex) begin
						indexSeen_q <= indexSeen_q + 1'b1;
						if (indexSeen_q == 2'h1) begin
							indSet_q[IND_ADDR] <= 1'b1;
							state_q <= ST_IDLE;
						end
					end else if (diskAddrValid && diskAddr == sectAddr_q) begin
						if (kind_q == DSS_OP_WRITE && diskReadOnly) begin
							indSet_q[IND_ADDR] <= 1'b1;
							state_q <= ST_IDLE;
						end else begin
							diskWriteGate_q <= kind_q == DSS_OP_WRITE;
							state_q <= ST_XFER;
						end
					end
				end
				ST_WAIT_INDEX: if (diskIndex) begin
					secInTrack_q <= 5'h00;
					diskWriteGate_q <= kind_q == DSS_OP_WRITE;
					state_q <= ST_XFER;
				end
				ST_NEXT_ADDR: begin
					// the core address steps one clock after the boundary, so skip that clock
					if (lenChk_q && kind_q == DSS_OP_READ && !advance_q && isGroupMark(coreRdData)) begin
						indSet_q[IND_WRONG_LEN] <= 1'b1;
						state_q <= ST_IDLE;
					end else if (diskAddrValid) begin
						if (diskAddr != sectAddr_q || (kind_q == DSS_OP_WRITE && diskReadOnly)) begin
							indSet_q[IND_ADDR] <= 1'b1;
							state_q <= ST_IDLE;
						end else begin
							diskWriteGate_q <= kind_q == DSS_OP_WRITE;
							state_q <= ST_XFER;
						end
					end
				end
				ST_XFER: begin
					if (wrCheck_q && !parityOk(diskCharOut_q)) begin
						indSet_q[IND_WRITE] <= 1'b1;
						diskWriteGate_q <= 1'b0;
						state_q <= ST_IDLE;
					end else if (diskCharStrobe) begin
						charCnt_q <= charCnt_q + 1'b1;
						unique case (kind_q)
							DSS_OP_READ: begin
								if (!parityOk(diskCharIn)) begin
									indSet_q <= mbrBit | IND_W'(1 << IND_READ);
									state_q <= ST_IDLE;
								end else begin
									// a core group mark here is overwritten like any character
									coreWrEn_q <= 1'b1;
									coreWrData_q <= diskCharIn;
									advance_q <= 1'b1;
									if (lenChk_q && track_q && isGroupMark(diskCharIn)) begin
										gmPend_q <= 1'b1;
									end
								end
							end
							DSS_OP_WRITE: begin
								if (!parityOk(coreRdData)) begin
									indSet_q <= mbrBit;
									diskWriteGate_q <= 1'b0;
									state_q <= ST_IDLE;
								end else begin
									// recorded group marks are never looked at on a write
									diskCharOut_q <= coreRdData;
									wrCheck_q <= 1'b1;
									advance_q <= 1'b1;
									if (lenChk_q && isGroupMark(coreRdData)) begin
										gmPend_q <= 1'b1;
									end
								end
							end
							default: begin
								if (!parityOk(diskCharIn) || !parityOk(coreRdData)) begin
									indSet_q <= (parityOk(coreRdData) ? '0 : mbrBit)
										| (parityOk(diskCharIn) ? '0 : IND_W'(1 << IND_READ));
									state_q <= ST_IDLE;
								end else begin
									advance_q <= 1'b1;
									if (diskCharIn != coreRdData) begin
										cmpFail_q <= 1'b1;
									end
									if (lenChk_q && (isGroupMark(diskCharIn) || isGroupMark(coreRdData))) begin
										gmPend_q <= 1'b1;
									end
								end
							end
						endcase
						if (charCnt_q == lastChar && (kind_q == DSS_OP_READ || parityOk(coreRdData))
							&& (kind_q == DSS_OP_WRITE || parityOk(diskCharIn))) begin
							// sector boundary; the drive paces each sector, so elapsed
							// time follows its rate plus the initial search
							charCnt_q <= 7'h00;
							sectAddr_q <= sectAddr_q + 1'b1;
							secInTrack_q <= secInTrack_q + 1'b1;
							if (!track_q) begin
								remaining_sector_count_q <= remaining_sector_count_q - 1'b1;
							end
							if (cmpFail_q || gmPend_q || (kind_q == DSS_OP_CMP && diskCharIn != coreRdData)) begin
								indSet_q[IND_WRONG_LEN] <= 1'b1;
								diskWriteGate_q <= 1'b0;
								state_q <= ST_IDLE;
							end else if (track_q) begin
								if (secInTrack_q == 5'(SECTORS_PER_TRACK - 1)) begin
									diskWriteGate_q <= 1'b0;
									state_q <= ST_IDLE;
								end
							end else if (remaining_sector_count_q == CNT_W'(1)) begin
								diskWriteGate_q <= 1'b0;
								state_q <= ST_IDLE;
							end else if (secInTrack_q == 5'(SECTORS_PER_TRACK - 1)) begin
								secInTrack_q <= 5'h00;
								if (head_q == 4'(SURFACES - 1)) begin
									indSet_q[IND_OVERFLOW] <= 1'b1;
									diskWriteGate_q <= 1'b0;
									state_q <= ST_IDLE;
								end else begin
									head_q <= head_q + 1'b1;
									state_q <= ST_NEXT_ADDR;
								end
							end else begin
								state_q <= ST_NEXT_ADDR;
							end
						end
					end
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	// ==========================================================
	// indicators: hardware set wins over a software write-one clear
	logic [IND_W-1:0] indClr;
	assign indClr = (wrAcc && avsAddress == REG_STATUS) ?
		IND_W'(mergeBytes(32'h00000000, avsWritedata, avsByteenable)) : '0;

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			ind_q <= '0;
			seekIrq_q <= 1'b0;
		end else if (clockEnable) begin
			ind_q <= (ind_q & ~indClr) | indSet_q;
			seekIrq_q <= SEEK_IRQ_FITTED && ind_q[IND_SEEK_DONE];
		end
	end

	assign avsReaddata = avsReaddata_q;
	assign avsWaitrequest = avsWaitrequest_q;
	assign seekHomeCmd = seekHomeCmd_q;
	assign seekMoveCmd = seekMoveCmd_q;
	assign seekCylinder = seekCyl_q;
	assign diskHead = head_q;
	assign diskWriteGate = diskWriteGate_q;
	assign diskCharOut = diskCharOut_q;
	assign coreAddr = coreAddr_q;
	assign coreWrEn = coreWrEn_q;
	assign coreWrData = coreWrData_q;
	assign seekCompleteIrq = seekIrq_q;

endmodule
